// ===== src/iopdc_consts.svh
// constants for the eight-pin port drive control block
// assumes inclusion by the package and design modules only
`ifndef IOPDC_CONSTS_SVH
`define IOPDC_CONSTS_SVH

`define IOPDC_NPINS       8
`define IOPDC_DM_W        3
`define IOPDC_OE_LINES    16
`define IOPDC_OE_SEL_W    4
`define IOPDC_USB_PIN_HI  7
`define IOPDC_USB_PIN_LO  6
`define IOPDC_DM_RESET    3'h0
`define IOPDC_DR_RESET    8'h00
`define IOPDC_PIN_REG_W   8
// pin-form register field positions
`define IOPDC_PF_DR       0
`define IOPDC_PF_PS       1
`define IOPDC_PF_DM_LSB   2
`define IOPDC_PF_BYP      5
`define IOPDC_PF_DIN      6
`define IOPDC_PF_BIDIR    7
// interrupt edge select codes
`define IOPDC_IRQ_OFF     2'h0
`define IOPDC_IRQ_RISE    2'h1
`define IOPDC_IRQ_FALL    2'h2
`define IOPDC_IRQ_BOTH    2'h3
// edges after reset before edge detection trusts the pin history
`define IOPDC_ARM_CYCLES  3'h4

`endif

// ===== src/iopdc_pkg.sv
// types for the eight-pin port drive control block
// assumes iopdc_consts.svh is on the include path
`include "iopdc_consts.svh"

package iopdc_pkg;

    typedef enum logic [2:0] {
        IOPDC_DM_HIZ_ANALOG,
        IOPDC_DM_HIZ_DIGITAL,
        IOPDC_DM_RES_PULLUP,
        IOPDC_DM_RES_PULLDOWN,
        IOPDC_DM_OD_LOW,
        IOPDC_DM_OD_HIGH,
        IOPDC_DM_STRONG,
        IOPDC_DM_RES_BOTH
    } iopdc_drive_mode_code_t;

    // per-pin pad control: strong and resistive drive enables with level
    typedef struct packed {
        logic strong_oe;
        logic res_oe;
        logic level;
        logic in_en;
    } iopdc_pad_t;

    // port-form write: one strobe plus data for a whole bank of bits
    typedef struct packed {
        logic                         we;
        logic [`IOPDC_NPINS-1:0]      data;
    } iopdc_port_wr_t;

    // pin-form write: pin index plus gathered eight-bit config
    typedef struct packed {
        logic                         we;
        logic [2:0]                   pin;
        logic [`IOPDC_PIN_REG_W-1:0]  data;
    } iopdc_pin_wr_t;

endpackage

// ===== src/iopdc_sync.sv
// two-flop synchroniser for a bank of pin inputs
// assumes asynchronous pins and a single system clock
`timescale 1ns/1ps
`include "iopdc_consts.svh"

module iopdc_sync
(
    input  wire logic                    i_mclk,   // system clock
    input  wire logic                    i_rst_b,  // async reset, active low
    input  wire logic [`IOPDC_NPINS-1:0] i_async,  // raw pin levels
    output logic      [`IOPDC_NPINS-1:0] o_sync    // synchronised levels
);
    logic [`IOPDC_NPINS-1:0] meta_q;

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_q <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// ===== src/iopdc_pad_decode.sv
// combinational drive-mode decode for one pin
// assumes output value already selected between register and fabric
`timescale 1ns/1ps

module iopdc_pad_decode
(
    input  wire logic [2:0]        i_dm,        // drive mode code
    input  wire logic              i_val,       // output value
    input  wire logic              i_bidir_in,  // bidir pin forced to input
    input  wire logic              i_regulated, // regulated output, no resistors
    input  wire logic              i_usb_io,    // pin is usb capable, io mode
    input  wire logic              i_usb_mode,  // usb mode, pad control ignored
    input  wire logic              i_usb_drv,   // usb pin drive enable
    input  wire logic              i_usb_pull,  // usb pin pull enable
    output iopdc_pkg::iopdc_pad_t  o_pad        // pad controls
);
    iopdc_pkg::iopdc_drive_mode_code_t mode;

    always_comb
    begin
        o_pad = '0;
        o_pad.level = i_val;
        mode = iopdc_pkg::iopdc_drive_mode_code_t'(i_dm);
        if (i_bidir_in)
            mode = iopdc_pkg::IOPDC_DM_HIZ_DIGITAL;
        if (i_usb_mode)
            o_pad = '0;
        else if (i_usb_io)
        begin
            o_pad.in_en = 1'b1;
            if (i_usb_drv)
                o_pad.strong_oe = 1'b1;
            else if (i_usb_pull)
            begin
                o_pad.strong_oe = !i_val;
                o_pad.res_oe    = i_val;
            end
            else
                o_pad.strong_oe = !i_val;
        end
        else
        begin
            o_pad.in_en = 1'b1;
            case (mode)
                iopdc_pkg::IOPDC_DM_HIZ_ANALOG:   o_pad.in_en = 1'b0;
                iopdc_pkg::IOPDC_DM_HIZ_DIGITAL:  o_pad.in_en = 1'b1;
                iopdc_pkg::IOPDC_DM_RES_PULLUP:
                begin
                    o_pad.strong_oe = !i_val;
                    o_pad.res_oe    = i_val;
                end
                iopdc_pkg::IOPDC_DM_RES_PULLDOWN:
                begin
                    o_pad.strong_oe = i_val;
                    o_pad.res_oe    = !i_val;
                end
                iopdc_pkg::IOPDC_DM_OD_LOW:   o_pad.strong_oe = !i_val;
                iopdc_pkg::IOPDC_DM_OD_HIGH:  o_pad.strong_oe = i_val;
                iopdc_pkg::IOPDC_DM_STRONG:   o_pad.strong_oe = 1'b1;
                iopdc_pkg::IOPDC_DM_RES_BOTH: o_pad.res_oe    = 1'b1;
                default:                      o_pad = '0;
            endcase
            // regulated output cannot use the resistors: they are simply dropped
            if (i_regulated)
                o_pad.res_oe = 1'b0;
        end
    end
endmodule

// ===== src/iopdc_port.sv
// Functional notes
// - every pin has its own three-bit drive mode code
// - code 0 disables driver and input buffer; reset default
// - code 1 is high impedance with digital input enabled
// - code 2 resistive high/strong low; code 3 strong high/resistive low
// - code 4 high impedance for one, strong low for zero
// - code 5 strong high for one, high impedance for zero
// - code 6 strong high and strong low
// - code 7 resistive high and resistive low
// - output value from fabric when bypass enabled, else data register
// - input always updates pin state; fabric sees it only when enabled
// - usb pins strong with drive enable, else open drain low
// - usb pin with pull enable only: resistive high, strong low
// - usb mode ignores drive bits; port-form drive-mode writes skip usb bits
// - regulated special pins lose the resistive drive modes
// - port-form registers, bit n for pin n
// - pin-form register gathers eight bits, same underlying state
// - pin state readback separate from output data register
// - bidirectional pins switch to digital input when enable low
// - rising, falling or both-edge interrupts per pin, no level
// - pin events merge into one port interrupt request
// - per-pin interrupt select: off, rising, falling, both
// - enabled edge sets status bit and raises port request
//
// eight-pin i/o port drive and data path control
// assumes config writes from cpu logic on i_mclk; pins are asynchronous
`timescale 1ns/1ps
`include "iopdc_consts.svh"

module iopdc_port
(
    input  wire logic                        i_mclk,         // system clock 10 MHz
    input  wire logic                        i_rst_b,        // async reset, active low
    // port-form configuration writes
    input  iopdc_pkg::iopdc_port_wr_t        i_dr_wr,        // output value register
    input  iopdc_pkg::iopdc_port_wr_t        i_dm0_wr,       // drive mode bit 0
    input  iopdc_pkg::iopdc_port_wr_t        i_dm1_wr,       // drive mode bit 1
    input  iopdc_pkg::iopdc_port_wr_t        i_dm2_wr,       // drive mode bit 2
    input  iopdc_pkg::iopdc_port_wr_t        i_byp_wr,       // fabric output select
    input  iopdc_pkg::iopdc_port_wr_t        i_din_wr,       // fabric input enable
    input  iopdc_pkg::iopdc_port_wr_t        i_bidir_wr,     // bidirectional enable
    input  iopdc_pkg::iopdc_port_wr_t        i_reg_wr,       // regulated output mode
    input  iopdc_pkg::iopdc_pin_wr_t         i_pin_wr,       // pin-form write
    input  wire logic [2:0]                  i_pin_rd_sel,   // pin-form read select
    input  wire logic [15:0]                 i_irq_mode,     // two bits per pin
    input  wire logic [`IOPDC_NPINS-1:0]     i_irq_clr,      // clear status bits
    input  wire logic [31:0]                 i_oe_sel,       // four bits per pin
    // usb-capable pins
    input  wire logic                        i_usb_mode,     // usb mode for pins 6,7
    input  wire logic [1:0]                  i_usb_drv_wr,   // drive enable values
    input  wire logic [1:0]                  i_usb_pull_wr,  // pull enable values
    input  wire logic                        i_usb_we,       // usb enable bits write
    // digital routing fabric
    input  wire logic [`IOPDC_NPINS-1:0]     i_fab_out,      // fabric output values
    input  wire logic [`IOPDC_OE_LINES-1:0]  i_fab_oe,       // output enable lines
    output logic      [`IOPDC_NPINS-1:0]     o_fab_in,       // gated pin inputs
    // pins
    input  wire logic [`IOPDC_NPINS-1:0]     i_pin,          // raw pin levels
    output logic      [`IOPDC_NPINS-1:0]     o_pin_level,    // driven level
    output logic      [`IOPDC_NPINS-1:0]     o_pin_oe,       // strong drive enable
    output logic      [`IOPDC_NPINS-1:0]     o_pin_res_oe,   // resistive drive enable
    output logic      [`IOPDC_NPINS-1:0]     o_pin_in_en,    // input buffer enable
    // readback and interrupt
    output logic      [`IOPDC_NPINS-1:0]     o_pin_state,    // synchronised pin state
    output logic      [`IOPDC_NPINS-1:0]     o_dr,           // output value register
    output logic      [`IOPDC_NPINS-1:0]     o_dm0,          // drive mode bit 0
    output logic      [`IOPDC_NPINS-1:0]     o_dm1,          // drive mode bit 1
    output logic      [`IOPDC_NPINS-1:0]     o_dm2,          // drive mode bit 2
    output logic      [`IOPDC_PIN_REG_W-1:0] o_pin_rd,       // pin-form readback
    output logic      [`IOPDC_NPINS-1:0]     o_irq_status,   // sticky edge status
    output logic                             o_irq           // port interrupt request
);
    localparam logic [7:0] USB_MASK = 8'hC0;

    logic [`IOPDC_NPINS-1:0] dr_q;
    logic [`IOPDC_NPINS-1:0] dm0_q;
    logic [`IOPDC_NPINS-1:0] dm1_q;
    logic [`IOPDC_NPINS-1:0] dm2_q;
    logic [`IOPDC_NPINS-1:0] byp_q;
    logic [`IOPDC_NPINS-1:0] din_q;
    logic [`IOPDC_NPINS-1:0] bidir_q;
    logic [`IOPDC_NPINS-1:0] regl_q;
    logic [`IOPDC_NPINS-1:0] ps_q;
    logic [`IOPDC_NPINS-1:0] ps_prev_q;
    logic [`IOPDC_NPINS-1:0] stat_q;
    logic [`IOPDC_NPINS-1:0] pin_sync;
    logic [`IOPDC_NPINS-1:0] out_val;
    logic [`IOPDC_NPINS-1:0] pin_oe_line;
    logic [`IOPDC_NPINS-1:0] edge_hit;
    logic [`IOPDC_NPINS-1:0] pin_onehot;
    logic [1:0]              usb_drv_q;
    logic [1:0]              usb_pull_q;

    // merges a port-form write with a pin-form write into one bank;
    // port write first, pin write on top so a single pin change wins
    function automatic logic [7:0] bank_next(input logic [7:0] cur,
                                              input logic       pwe,
                                              input logic [7:0] pdata,
                                              input logic [7:0] keep,
                                              input logic       swe,
                                              input logic [7:0] sel,
                                              input logic       sbit);
        logic [7:0] v;
        v = cur;
        if (pwe)
            v = (pdata & ~keep) | (cur & keep);
        if (swe)
            v = (v & ~sel) | ({8{sbit}} & sel);
        return v;
    endfunction

    assign pin_onehot = 8'h01 << i_pin_wr.pin;

    // usb pins keep their drive bits untouched by port-form writes
    logic [7:0] keep_dm;
    logic       pin_wr_ok;
    assign keep_dm   = USB_MASK;
    assign pin_wr_ok = i_pin_wr.we;

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            dr_q <= `IOPDC_DR_RESET;
        end
        else
        begin
            dr_q <= bank_next(dr_q, i_dr_wr.we, i_dr_wr.data, 8'h00, pin_wr_ok,
                              pin_onehot, i_pin_wr.data[`IOPDC_PF_DR]);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            dm0_q <= '0;
            dm1_q <= '0;
            dm2_q <= '0;
        end
        else
        begin
            dm0_q <= bank_next(dm0_q, i_dm0_wr.we, i_dm0_wr.data, keep_dm, pin_wr_ok,
                               pin_onehot, i_pin_wr.data[`IOPDC_PF_DM_LSB]);
            dm1_q <= bank_next(dm1_q, i_dm1_wr.we, i_dm1_wr.data, keep_dm, pin_wr_ok,
                               pin_onehot, i_pin_wr.data[`IOPDC_PF_DM_LSB+1]);
            dm2_q <= bank_next(dm2_q, i_dm2_wr.we, i_dm2_wr.data, keep_dm, pin_wr_ok,
                               pin_onehot, i_pin_wr.data[`IOPDC_PF_DM_LSB+2]);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            byp_q   <= '0;
            din_q   <= '0;
            bidir_q <= '0;
            regl_q  <= '0;
        end
        else
        begin
            byp_q   <= bank_next(byp_q, i_byp_wr.we, i_byp_wr.data, 8'h00, pin_wr_ok,
                                 pin_onehot, i_pin_wr.data[`IOPDC_PF_BYP]);
            din_q   <= bank_next(din_q, i_din_wr.we, i_din_wr.data, 8'h00, pin_wr_ok,
                                 pin_onehot, i_pin_wr.data[`IOPDC_PF_DIN]);
            bidir_q <= bank_next(bidir_q, i_bidir_wr.we, i_bidir_wr.data, 8'h00,
                                 pin_wr_ok, pin_onehot, i_pin_wr.data[`IOPDC_PF_BIDIR]);
            if (i_reg_wr.we)
                regl_q <= i_reg_wr.data;
        end
    end

    // usb enable bits are written only through their own strobe
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            usb_drv_q  <= '0;
            usb_pull_q <= '0;
        end
        else if (i_usb_we)
        begin
            usb_drv_q  <= i_usb_drv_wr;
            usb_pull_q <= i_usb_pull_wr;
        end
    end

    iopdc_sync u_sync
    (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_async (i_pin),
        .o_sync  (pin_sync)                                                  
    );

    // pin state is fed only from the synchronised pins, never from dr_q
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ps_q      <= '0;
            ps_prev_q <= '0;
        end
        else
        begin
            ps_q      <= pin_sync;
            ps_prev_q <= ps_q;
        end
    end

    // edge detection waits until the history flops hold real pin levels,
    // otherwise a pin idling high looks like a rising edge right after reset
    logic [2:0] arm_q;

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            arm_q <= 3'h0;
        else if (arm_q != `IOPDC_ARM_CYCLES)
            arm_q <= arm_q + 3'h1;
    end

    function automatic logic edge_match(input logic [1:0] m,
                                        input logic       now,
                                        input logic       was);
        logic r;
        r = 1'b0;
        case (m)
            `IOPDC_IRQ_RISE: r = now & ~was;
            `IOPDC_IRQ_FALL: r = ~now & was;
            `IOPDC_IRQ_BOTH: r = now ^ was;
            default:         r = 1'b0;
        endcase
        return r;
    endfunction

    always_comb
    begin
        for (int i = 0; i < `IOPDC_NPINS; i++)
        begin
            edge_hit[i]    = edge_match(i_irq_mode[2*i +: 2], ps_q[i], ps_prev_q[i])
                             && (arm_q == `IOPDC_ARM_CYCLES);
            pin_oe_line[i] = i_fab_oe[i_oe_sel[4*i +: 4]];
            out_val[i]     = byp_q[i] ? i_fab_out[i] : dr_q[i];
        end
    end

    // a new edge beats a clear in the same cycle
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            stat_q <= '0;
        else
            stat_q <= (stat_q & ~i_irq_clr) | edge_hit;
    end

    generate
        for (genvar g = 0; g < `IOPDC_NPINS; g++)
        begin : g_pad
            iopdc_pkg::iopdc_pad_t pad;
            logic                  is_usb;
            assign is_usb = (g >= `IOPDC_USB_PIN_LO);
            iopdc_pad_decode u_dec
            (
                .i_dm        ({dm2_q[g], dm1_q[g], dm0_q[g]}),
                .i_val       (out_val[g]),
                .i_bidir_in  (bidir_q[g] & ~pin_oe_line[g]),
                .i_regulated (regl_q[g]),
                .i_usb_io    (is_usb & ~i_usb_mode),
                .i_usb_mode  (is_usb & i_usb_mode),
                .i_usb_drv   (usb_drv_q[g >= `IOPDC_USB_PIN_HI]),
                .i_usb_pull  (usb_pull_q[g >= `IOPDC_USB_PIN_HI]),
                .o_pad       (pad)
            );
            assign o_pin_level[g]  = pad.level;
            assign o_pin_oe[g]     = pad.strong_oe;
            assign o_pin_res_oe[g] = pad.res_oe;
            assign o_pin_in_en[g]  = pad.in_en;
        end
    endgenerate

    assign o_fab_in     = ps_q & din_q;
    assign o_pin_state  = ps_q;
    assign o_dr         = dr_q;
    assign o_dm0        = dm0_q;
    assign o_dm1        = dm1_q;
    assign o_dm2        = dm2_q;
    assign o_irq_status = stat_q;
    assign o_irq        = |stat_q;

    always_comb
    begin
        o_pin_rd = '0;
        o_pin_rd[`IOPDC_PF_DR]          = dr_q[i_pin_rd_sel];
        o_pin_rd[`IOPDC_PF_PS]          = ps_q[i_pin_rd_sel];
        o_pin_rd[`IOPDC_PF_DM_LSB]      = dm0_q[i_pin_rd_sel];
        o_pin_rd[`IOPDC_PF_DM_LSB+1]    = dm1_q[i_pin_rd_sel];
        o_pin_rd[`IOPDC_PF_DM_LSB+2]    = dm2_q[i_pin_rd_sel];
        o_pin_rd[`IOPDC_PF_BYP]         = byp_q[i_pin_rd_sel];
        o_pin_rd[`IOPDC_PF_DIN]         = din_q[i_pin_rd_sel];
        o_pin_rd[`IOPDC_PF_BIDIR]       = bidir_q[i_pin_rd_sel];
    end

    property p_reset_hiz;
        @(posedge i_mclk) disable iff (!i_rst_b)
        $rose(i_rst_b) |-> (o_pin_oe[5:0] == 6'h00);
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("pin driven after reset");

    property p_ps_sync;
        @(posedge i_mclk) disable iff (!i_rst_b)
        ##3 1'b1 |-> (o_pin_state == $past(i_pin, 3));
    endproperty
    a_ps_sync: assert property (p_ps_sync) else $error("pin state latency not three");

    property p_dr_hold;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!i_dr_wr.we && !i_pin_wr.we) |=> (o_dr == $past(o_dr));
    endproperty
    a_dr_hold: assert property (p_dr_hold) else $error("output register changed");

    property p_strong;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (o_dm2[0] && o_dm1[0] && !o_dm0[0] && !bidir_q[0]) |-> o_pin_oe[0];
    endproperty
    a_strong: assert property (p_strong) else $error("strong mode not driving");

    property p_od_low;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (o_dm2[0] && !o_dm1[0] && !o_dm0[0] && !bidir_q[0])
            |-> (o_pin_oe[0] == !o_pin_level[0] && !o_pin_res_oe[0]);
    endproperty
    a_od_low: assert property (p_od_low) else $error("open drain low wrong");

    property p_irq_set;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (edge_hit != 8'h00) |=> (o_irq && ((o_irq_status & $past(edge_hit)) == $past(edge_hit)));
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("edge lost");

    property p_fab_in;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (din_q == 8'h00) |-> (o_fab_in == 8'h00);
    endproperty
    a_fab_in: assert property (p_fab_in) else $error("fabric input not gated");

    property p_usb_keep;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_dm0_wr.we && !i_pin_wr.we) |=> (o_dm0[7:6] == $past(o_dm0[7:6]));
    endproperty
    a_usb_keep: assert property (p_usb_keep) else $error("port write hit usb bits");
endmodule

// ===== testbench/iopdc_board.sv
// board model: external circuitry on the eight port pins
// assumes pad controls from the port and a weak pull-down on every pin
`timescale 1ns/1ps

module iopdc_board
(
    input  wire logic [7:0] i_oe,      // strong drive enable
    input  wire logic [7:0] i_res_oe,  // resistive drive enable
    input  wire logic [7:0] i_level,   // device level
    input  wire logic [7:0] i_ext_en,  // external driver on
    input  wire logic [7:0] i_ext_val, // external driver level
    output logic      [7:0] o_pin      // resolved pin level
);
    // strong beats external, external beats a resistor, pull-down when nobody drives
    always_comb
    begin
        for (int n = 0; n < 8; n++)
        begin
            if (i_oe[n])
                o_pin[n] = i_level[n];
            else if (i_ext_en[n])
                o_pin[n] = i_ext_val[n];
            else if (i_res_oe[n])
                o_pin[n] = i_level[n];
            else
                o_pin[n] = 1'b0;
        end
    end
endmodule

// ===== testbench/io_pin_drive_control_test.sv
// self-checking bench for the eight-pin port drive control
// assumes iopdc_port as the design top and iopdc_board on the pins
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module io_pin_drive_control_test;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    iopdc_pkg::iopdc_port_wr_t wr_s [8]; // dr dm0 dm1 dm2 byp din bidir reg
    iopdc_pkg::iopdc_pin_wr_t pw = '0;
    logic [2:0] rd_sel = 3'h0;
    logic [15:0] irq_mode = 16'h0000, fab_oe = 16'h0000;
    logic [7:0] irq_clr = 8'h00, fab_out = 8'h00, ext_en = 8'hFF, ext_val = 8'h00, pin;
    logic [1:0] usb_drv = 2'h0, usb_pull = 2'h0;
    logic usb_we = 1'b0, usb_mode = 1'b0;
    logic [7:0] oe, res, lvl, in_en, ps, dr, dm0, dm1, dm2, rdb, st, fin;
    logic irq;
    int failures = 0, comparisons = 0, cyc = 0;

    iopdc_port i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_dr_wr(wr_s[0]), .i_dm0_wr(wr_s[1]),
        .i_dm1_wr(wr_s[2]), .i_dm2_wr(wr_s[3]), .i_byp_wr(wr_s[4]), .i_din_wr(wr_s[5]),
        .i_bidir_wr(wr_s[6]), .i_reg_wr(wr_s[7]), .i_pin_wr(pw), .i_pin_rd_sel(rd_sel),
        .i_irq_mode(irq_mode), .i_irq_clr(irq_clr), .i_oe_sel(32'h0000_0003),
        .i_usb_mode(usb_mode), .i_usb_drv_wr(usb_drv), .i_usb_pull_wr(usb_pull),
        .i_usb_we(usb_we), .i_fab_out(fab_out), .i_fab_oe(fab_oe), .o_fab_in(fin), .i_pin(pin),
        .o_pin_level(lvl), .o_pin_oe(oe), .o_pin_res_oe(res), .o_pin_in_en(in_en),
        .o_pin_state(ps), .o_dr(dr), .o_dm0(dm0), .o_dm1(dm1), .o_dm2(dm2), .o_pin_rd(rdb),
        .o_irq_status(st), .o_irq(irq));
    iopdc_board i_board (.i_oe(oe), .i_res_oe(res), .i_level(lvl), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .o_pin(pin));

    initial
    begin
        forever #50 i_mclk = ~i_mclk;
    end

    // a hang counts as a mismatch and ends the run through the same report
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            conclude();
        end
    end

    // expected {strong, resistive, input enable} for drive code and value
    function automatic logic [2:0] pad_exp(input logic [2:0] c, input logic v);
        logic s;
        logic r;
        s = (c == 3'h6) || (v && (c == 3'h3 || c == 3'h5)) || (!v && (c == 3'h2 || c == 3'h4));
        r = (c == 3'h7) || (v && c == 3'h2) || (!v && c == 3'h3);
        return {s, r, c != 3'h0};
    endfunction

    task automatic wr(input int b, input logic [7:0] d);
        @(posedge i_mclk);
        wr_s[b] <= '{1'b1, d};
        @(posedge i_mclk);
        wr_s[b].we <= 1'b0;
        @(negedge i_mclk);
    endtask

    task automatic usb_wr(input logic [1:0] drv, input logic [1:0] pull);
        @(posedge i_mclk);
        {usb_we, usb_drv, usb_pull} <= {1'b1, drv, pull};
        @(posedge i_mclk);
        usb_we <= 1'b0;
        @(negedge i_mclk);
    endtask

    task automatic conclude();
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        for (int b = 0; b < 8; b++)
            wr_s[b] = '0;
        repeat (4) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(negedge i_mclk);
        `CHK("reset_pads", 16'hC0C0, {oe | res, in_en})
        for (int c = 0; c < 8; c++)
        begin
            wr(1, {7'h00, c[0]});
            wr(2, {7'h00, c[1]});
            wr(3, {7'h00, c[2]});
            for (int v = 0; v < 2; v++)
            begin
                wr(0, {7'h00, v[0]});
                `CHK("pad", pad_exp(c[2:0], v[0]), {oe[0], res[0], in_en[0]})
                if (oe[0] | res[0])
                    `CHK("level", v[0], lvl[0])
            end
        end
        wr(7, 8'h01);
        `CHK("regulated", 2'b00, {oe[0], res[0]})
        wr(7, 8'h00);
        wr(3, 8'h01);
        wr(2, 8'h01);
        wr(1, 8'h00);
        wr(4, 8'h01);
        @(posedge i_mclk);
        fab_out <= 8'h00;
        @(negedge i_mclk);
        `CHK("bypass_lo", 1'b0, lvl[0])
        @(posedge i_mclk);
        fab_out <= 8'h01;
        @(negedge i_mclk);
        `CHK("bypass_hi", 1'b1, lvl[0])
        wr(6, 8'h01);
        `CHK("bidir_in", 2'b01, {oe[0], in_en[0]})
        @(posedge i_mclk);
        fab_oe <= 16'h0008;
        @(negedge i_mclk);
        `CHK("bidir_out", 1'b1, oe[0])
        ext_en <= 8'hFB;
        ext_val <= 8'h08;
        @(posedge i_mclk);
        pw <= '{1'b1, 3'h2, 8'h59};
        rd_sel <= 3'h2;
        @(posedge i_mclk);
        pw.we <= 1'b0;
        repeat (4) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("pin_form_dm", 3'b110, {dm2[2], dm1[2], dm0[2]})
        `CHK("pin_form_rd", 8'h59, rdb & 8'hFD)
        `CHK("pin_state", 2'b11, {ps[3], ps[2]})
        `CHK("fabric_in", 2'b01, {fin[3], fin[2]})
        `CHK("dr_kept", 1'b1, dr[2])
        @(posedge i_mclk);
        irq_mode <= 16'h0004;
        ext_val <= 8'h0A;
        for (int k = 0; k < 10 && irq !== 1'b1; k++)
            @(negedge i_mclk);
        `CHK("irq_rise", 9'h102, {irq, st})
        @(posedge i_mclk);
        irq_clr <= 8'h02;
        @(posedge i_mclk);
        irq_clr <= 8'h00;
        ext_val <= 8'h08;
        repeat (8) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("irq_fall_ignored", 9'h000, {irq, st})
        @(posedge i_mclk);
        irq_mode <= 16'h0008;
        ext_val <= 8'h0A;
        repeat (8) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("irq_rise_under_fall", 9'h000, {irq, st})
        ext_val <= 8'h08;
        repeat (8) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("irq_fall", 9'h102, {irq, st})
        @(posedge i_mclk);
        irq_clr <= 8'h02;
        irq_mode <= 16'h000C;
        @(posedge i_mclk);
        irq_clr <= 8'h00;
        ext_val <= 8'h0A;
        repeat (8) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("irq_both", 9'h102, {irq, st})
        wr(0, 8'h80);
        usb_wr(2'b00, 2'b10);
        `CHK("usb_pull", 2'b01, {oe[7], res[7]})
        usb_wr(2'b00, 2'b00);
        `CHK("usb_od", 2'b00, {oe[7], res[7]})
        usb_wr(2'b10, 2'b00);
        `CHK("usb_strong", 1'b1, oe[7])
        wr(1, 8'hC0);
        `CHK("usb_port_wr", 3'b100, {oe[7], dm0[7:6]})
        @(posedge i_mclk);
        usb_mode <= 1'b1;
        @(negedge i_mclk);
        `CHK("usb_mode", 2'b00, {oe[7], res[7]})
        conclude();
    end
endmodule
